// >>> atdu_defs.vh
// constants for the adc trigger delay unit: register map, fields, codes
// assumes inclusion by bare name from the unit's design files
`ifndef ATDU_DEFS_VH
`define ATDU_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ATDU_OFS_CONTROL   5'h00
`define ATDU_OFS_CYCLE_A   5'h04
`define ATDU_OFS_CYCLE_B   5'h08
`define ATDU_OFS_BUFFER_A  5'h0c
`define ATDU_OFS_BUFFER_B  5'h10
`define ATDU_OFS_MONITOR0  5'h14
`define ATDU_OFS_MONITOR1  5'h18
`define ATDU_OFS_STATUS    5'h1c

// ----------------------------------------------------------------
// control register fields and reset values
// ----------------------------------------------------------------
`define ATDU_CTL_UP_A      0
`define ATDU_CTL_DOWN_A    1
`define ATDU_CTL_UP_B      2
`define ATDU_CTL_DOWN_B    3
`define ATDU_CTL_TT_LO     6
`define ATDU_CTL_TT_HI     7
`define ATDU_CTL_RESET     8'h00
`define ATDU_CYCLE_RESET   16'h0000
`define ATDU_ZERO_VALUE    16'h0000

// ----------------------------------------------------------------
// transfer timing codes
// ----------------------------------------------------------------
`define ATDU_TT_NONE       2'h0
`define ATDU_TT_CREST      2'h1
`define ATDU_TT_TROUGH     2'h2
`define ATDU_TT_BOTH       2'h3

// ----------------------------------------------------------------
// timer operating modes
// ----------------------------------------------------------------
`define ATDU_MODE_NORMAL   2'h0
`define ATDU_MODE_PWM1     2'h1
`define ATDU_MODE_RSYNC    2'h2
`define ATDU_MODE_COMPL    2'h3

// ----------------------------------------------------------------
// monitor select register fields and source codes
// ----------------------------------------------------------------
`define ATDU_MON_SEL_HI    4
`define ATDU_MON_EN        7
`define ATDU_MON_RESET     8'h00
`define ATDU_SRC_TRIG_A    5'h09
`define ATDU_SRC_TRIG_B    5'h0a
`define ATDU_SRC_TRIG_AB   5'h0c

`endif

// >>> atdu_monitor.v
// frame synchronous monitor pin driver for one monitor output
// assumes trigger pulses and cycle end come from logic on clk_sys_in
`timescale 1ns/1ps
`default_nettype none
`include "atdu_defs.vh"

module atdu_monitor (
   input  wire       clk_sys_in,
   input  wire       rst_n_in,
   input  wire       ce_in,
   input  wire [4:0] source_sel_in,
   input  wire       out_enable_in,
   input  wire       trigger_a_in,
   input  wire       trigger_b_in,
   input  wire       cycle_end_in,
   output reg        frame_sync_pin_out,
   output reg        frame_sync_oe_n_out
);

   // ----------------------------------------------------------------
   // source selection
   // ----------------------------------------------------------------
   reg selected;
   reg known;

   // unknown codes select nothing and leave the pin undriven
   always @* begin
      known = 1'b1;
      if (source_sel_in == `ATDU_SRC_TRIG_A) begin
         selected = trigger_a_in;
      end else if (source_sel_in == `ATDU_SRC_TRIG_B) begin
         selected = trigger_b_in;
      end else if (source_sel_in == `ATDU_SRC_TRIG_AB) begin
         selected = trigger_a_in | trigger_b_in;
      end else begin
         selected = 1'b0;
         known    = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // pulse: rise on trigger, fall at end of the counter cycle
   // ----------------------------------------------------------------
   // a trigger in the cycle-end cycle wins so no pulse is lost
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         frame_sync_pin_out  <= 1'b0;
         frame_sync_oe_n_out <= 1'b1;
      end else if (ce_in) begin
         frame_sync_oe_n_out <= ~(out_enable_in & known);
         if (!(out_enable_in & known)) begin
            frame_sync_pin_out <= 1'b0;
         end else if (selected) begin
            frame_sync_pin_out <= 1'b1;
         end else if (cycle_end_in) begin
            frame_sync_pin_out <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// >>> atdu_trigger_unit.v
// adc trigger delay unit: compare based delayed conversion start triggers
// assumes counter, direction and timing strobes come from the timer
// channel on clk_sys_in; registers over avalon-mm with waitrequest
`timescale 1ns/1ps
`default_nettype none
`include "atdu_defs.vh"

module atdu_trigger_unit (
   input  wire        clk_sys_in,
   input  wire        rst_n_in,
   input  wire        ce_in,
   // avalon-mm slave
   input  wire [4:0]  avs_address_in,
   input  wire        avs_read_in,
   input  wire        avs_write_in,
   input  wire [31:0] avs_writedata_in,
   input  wire [3:0]  avs_byteenable_in,
   output reg  [31:0] avs_readdata_out,
   output reg         avs_waitrequest_out,
   // timer channel
   input  wire [15:0] channel_counter_in,
   input  wire        count_down_in,
   input  wire [1:0]  timer_mode_in,
   input  wire        crest_in,
   input  wire        trough_in,
   input  wire        general_reg_a_match_in,
   input  wire        duty_reg_d_rewrite_in,
   input  wire [15:0] offset_cycle_value_in,
   input  wire        cycle_end_in,
   // converter and pins
   output reg         trigger_a_out,
   output reg         trigger_b_out,
   output reg         trigger_a_or_b_out,
   output wire        frame_sync_pin0_out,
   output wire        frame_sync_oe0_n_out,
   output wire        frame_sync_pin1_out,
   output wire        frame_sync_oe1_n_out
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // byte-lane merge for 16-bit registers
   function [15:0] merge16;
      input [15:0] old_val;
      input [31:0] wdata;
      input [3:0]  be;
      begin
         merge16[7:0]  = be[0] ? wdata[7:0]  : old_val[7:0];
         merge16[15:8] = be[1] ? wdata[15:8] : old_val[15:8];
      end
   endfunction

   // enabled compare match for one trigger
   function match_hit;
      input [15:0] counter;
      input [15:0] cycle;
      input        down;
      input        up_en;
      input        down_en;
      input        blocked;
      begin
         match_hit = (counter == cycle) && !blocked &&
                     (down ? down_en : up_en);
      end
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   reg  [7:0]  trig_control;
   reg  [15:0] trig_cycle_a;
   reg  [15:0] trig_cycle_b;
   reg  [15:0] trig_cycle_a_buffer;
   reg  [15:0] trig_cycle_b_buffer;
   reg  [7:0]  monitor_select_reg0;
   reg  [7:0]  monitor_select_reg1;
   reg         skip_a;
   reg         skip_b;

   wire        access    = avs_read_in | avs_write_in;
   wire        commit_wr = avs_write_in & ~avs_waitrequest_out;
   wire        compl     = (timer_mode_in == `ATDU_MODE_COMPL);
   wire [1:0]  tt_sel    = trig_control[`ATDU_CTL_TT_HI:`ATDU_CTL_TT_LO];

   // down enables only honoured in complementary mode
   wire        down_en_a = trig_control[`ATDU_CTL_DOWN_A] & compl;
   wire        down_en_b = trig_control[`ATDU_CTL_DOWN_B] & compl;

   // ----------------------------------------------------------------
   // transfer timing decode
   // ----------------------------------------------------------------
   reg xfer;
   reg xfer_trough;
   reg xfer_crest;

   always @* begin
      xfer_crest  = 1'b0;
      xfer_trough = 1'b0;
      xfer        = 1'b0;
      if (compl) begin
         xfer_crest  = crest_in &
                       (tt_sel == `ATDU_TT_CREST ||
                        tt_sel == `ATDU_TT_BOTH);
         xfer_trough = trough_in &
                       (tt_sel == `ATDU_TT_TROUGH ||
                        tt_sel == `ATDU_TT_BOTH);
         xfer = xfer_crest | xfer_trough | duty_reg_d_rewrite_in;
      end else begin
         // codes 10 and 11 are prohibited here and give no transfer
         xfer = general_reg_a_match_in &
                (tt_sel == `ATDU_TT_CREST);
      end
   end

   // ----------------------------------------------------------------
   // bus handshake: one wait cycle, then the access completes
   // ----------------------------------------------------------------
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out    <= 32'h00000000;
      end else if (ce_in) begin
         avs_waitrequest_out <= ~(access & avs_waitrequest_out);
         // read data sampled in the wait cycle, stable at completion
         if (avs_address_in == `ATDU_OFS_CONTROL) begin
            avs_readdata_out <= {24'h000000, trig_control};
         end else if (avs_address_in == `ATDU_OFS_CYCLE_A) begin
            avs_readdata_out <= {16'h0000, trig_cycle_a};
         end else if (avs_address_in == `ATDU_OFS_CYCLE_B) begin
            avs_readdata_out <= {16'h0000, trig_cycle_b};
         end else if (avs_address_in == `ATDU_OFS_BUFFER_A) begin
            avs_readdata_out <= {16'h0000, trig_cycle_a_buffer};
         end else if (avs_address_in == `ATDU_OFS_BUFFER_B) begin
            avs_readdata_out <= {16'h0000, trig_cycle_b_buffer};
         end else if (avs_address_in == `ATDU_OFS_MONITOR0) begin
            avs_readdata_out <= {24'h000000, monitor_select_reg0};
         end else if (avs_address_in == `ATDU_OFS_MONITOR1) begin
            avs_readdata_out <= {24'h000000, monitor_select_reg1};
         end else if (avs_address_in == `ATDU_OFS_STATUS) begin
            avs_readdata_out <= {28'h0000000, skip_b, skip_a,
                                 count_down_in, compl};
         end else begin
            avs_readdata_out <= 32'h00000000;
         end
      end
   end

   // ----------------------------------------------------------------
   // software registers (active cycle registers are read only)
   // ----------------------------------------------------------------
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         trig_control        <= `ATDU_CTL_RESET;
         trig_cycle_a_buffer <= `ATDU_CYCLE_RESET;
         trig_cycle_b_buffer <= `ATDU_CYCLE_RESET;
         monitor_select_reg0 <= `ATDU_MON_RESET;
         monitor_select_reg1 <= `ATDU_MON_RESET;
      end else if (ce_in && commit_wr && avs_byteenable_in[0]) begin
         if (avs_address_in == `ATDU_OFS_CONTROL) begin
            trig_control <= avs_writedata_in[7:0];
         end else if (avs_address_in == `ATDU_OFS_MONITOR0) begin
            monitor_select_reg0 <= avs_writedata_in[7:0];
         end else if (avs_address_in == `ATDU_OFS_MONITOR1) begin
            monitor_select_reg1 <= avs_writedata_in[7:0];
         end else if (avs_address_in == `ATDU_OFS_BUFFER_A) begin
            trig_cycle_a_buffer <= merge16(trig_cycle_a_buffer,
                                   avs_writedata_in, avs_byteenable_in);
         end else if (avs_address_in == `ATDU_OFS_BUFFER_B) begin
            trig_cycle_b_buffer <= merge16(trig_cycle_b_buffer,
                                   avs_writedata_in, avs_byteenable_in);
         end
      end else if (ce_in && commit_wr && avs_byteenable_in[1]) begin
         // upper-lane-only writes reach only the 16-bit buffers
         if (avs_address_in == `ATDU_OFS_BUFFER_A) begin
            trig_cycle_a_buffer <= merge16(trig_cycle_a_buffer,
                                   avs_writedata_in, avs_byteenable_in);
         end else if (avs_address_in == `ATDU_OFS_BUFFER_B) begin
            trig_cycle_b_buffer <= merge16(trig_cycle_b_buffer,
                                   avs_writedata_in, avs_byteenable_in);
         end
      end
   end

   // ----------------------------------------------------------------
   // buffer transfer and post-transfer suppression
   // ----------------------------------------------------------------
   // a trough copy of zero would match at the trough itself and fire
   // once on the way up; a crest copy of the offset value likewise on
   // the way down. both are masked until the opposite turning point.
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         trig_cycle_a <= `ATDU_CYCLE_RESET;
         trig_cycle_b <= `ATDU_CYCLE_RESET;
         skip_a       <= 1'b0;
         skip_b       <= 1'b0;
      end else if (ce_in) begin
         if (xfer) begin
            trig_cycle_a <= trig_cycle_a_buffer;
            trig_cycle_b <= trig_cycle_b_buffer;
         end
         if (xfer_trough) begin
            skip_a <= (trig_cycle_a_buffer == `ATDU_ZERO_VALUE);
            skip_b <= (trig_cycle_b_buffer == `ATDU_ZERO_VALUE);
         end else if (xfer_crest) begin
            skip_a <= (trig_cycle_a_buffer == offset_cycle_value_in);
            skip_b <= (trig_cycle_b_buffer == offset_cycle_value_in);
         end else if (crest_in | trough_in | ~compl) begin
            skip_a <= 1'b0;
            skip_b <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // trigger generation
   // ----------------------------------------------------------------
   reg hit_a;
   reg hit_b;

   always @* begin
      hit_a = match_hit(channel_counter_in, trig_cycle_a, count_down_in,
                        trig_control[`ATDU_CTL_UP_A], down_en_a,
                        skip_a);
      hit_b = match_hit(channel_counter_in, trig_cycle_b, count_down_in,
                        trig_control[`ATDU_CTL_UP_B], down_en_b,
                        skip_b);
   end

   // registered so each match gives exactly one clock of trigger;
   // a counter holding on the match value keeps it high, by design
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         trigger_a_out      <= 1'b0;
         trigger_b_out      <= 1'b0;
         trigger_a_or_b_out <= 1'b0;
      end else if (ce_in) begin
         trigger_a_out      <= hit_a;
         trigger_b_out      <= hit_b;
         trigger_a_or_b_out <= hit_a | hit_b;
      end
   end

   // ----------------------------------------------------------------
   // monitor pins
   // ----------------------------------------------------------------
   atdu_monitor u_mon0 (
      .clk_sys_in          (clk_sys_in),
      .rst_n_in            (rst_n_in),
      .ce_in               (ce_in),
      .source_sel_in       (monitor_select_reg0[`ATDU_MON_SEL_HI:0]),
      .out_enable_in       (monitor_select_reg0[`ATDU_MON_EN]),
      .trigger_a_in        (trigger_a_out),
      .trigger_b_in        (trigger_b_out),
      .cycle_end_in        (cycle_end_in),
      .frame_sync_pin_out  (frame_sync_pin0_out),
      .frame_sync_oe_n_out (frame_sync_oe0_n_out)
   );

   atdu_monitor u_mon1 (
      .clk_sys_in          (clk_sys_in),
      .rst_n_in            (rst_n_in),
      .ce_in               (ce_in),
      .source_sel_in       (monitor_select_reg1[`ATDU_MON_SEL_HI:0]),
      .out_enable_in       (monitor_select_reg1[`ATDU_MON_EN]),
      .trigger_a_in        (trigger_a_out),
      .trigger_b_in        (trigger_b_out),
      .cycle_end_in        (cycle_end_in),
      .frame_sync_pin_out  (frame_sync_pin1_out),
      .frame_sync_oe_n_out (frame_sync_oe1_n_out)
   );

endmodule
`default_nettype wire

// >>> atdu_checker_assertions.sv
// checker for the adc trigger delay unit: bus handshake, trigger pulses,
// monitor pin 0; assumes bind onto atdu_trigger_unit, single clock
`timescale 1ns/1ps
`default_nettype none
module atdu_checker (
   input wire logic       clk_sys_in,
   input wire logic       rst_n_in,
   input wire logic       ce_in,
   input wire logic       avs_read_in,
   input wire logic       avs_write_in,
   input wire logic       avs_waitrequest_out,
   input wire logic [1:0] timer_mode_in,
   input wire logic       count_down_in,
   input wire logic       cycle_end_in,
   input wire logic       trigger_a_out,
   input wire logic       trigger_b_out,
   input wire logic       trigger_a_or_b_out,
   input wire logic       frame_sync_pin0_out,
   input wire logic       frame_sync_oe0_n_out
);
   default clocking cb_sys @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   // ---------------------------------------------------------------
   // bus: exactly one wait cycle, then a one-cycle release
   // ---------------------------------------------------------------
   a_wait_one_cycle: assert property ((avs_read_in || avs_write_in)
      && avs_waitrequest_out && ce_in |=> !avs_waitrequest_out)
      else $error("request not answered after one wait cycle");
   a_wait_back_high: assert property (!avs_waitrequest_out && ce_in
      |=> avs_waitrequest_out)
      else $error("waitrequest low for more than one cycle");
   a_idle_stall: assert property (!avs_read_in && !avs_write_in
      && avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("waitrequest dropped without a request");
   // ---------------------------------------------------------------
   // triggers: single pulses, only in an allowed direction
   // ---------------------------------------------------------------
   a_trig_a_pulse: assert property (trigger_a_out |=> !trigger_a_out)
      else $error("trigger a wider than one cycle");
   a_trig_b_pulse: assert property (trigger_b_out |=> !trigger_b_out)
      else $error("trigger b wider than one cycle");
   a_or_combined: assert property (trigger_a_or_b_out
      == (trigger_a_out || trigger_b_out))
      else $error("combined trigger differs from a or b");
   a_down_blocked: assert property (trigger_a_out || trigger_b_out |->
      !$past(count_down_in) || $past(timer_mode_in) == 2'h3)
      else $error("down count trigger outside complementary mode");
   // ---------------------------------------------------------------
   // monitor pin: rises after a trigger, falls after the cycle end
   // ---------------------------------------------------------------
   a_pin_rise: assert property ($rose(frame_sync_pin0_out) |->
      $past(trigger_a_or_b_out))
      else $error("monitor pin rose without a trigger");
   a_pin_enabled: assert property (frame_sync_pin0_out |->
      !frame_sync_oe0_n_out)
      else $error("monitor pin high while not enabled");
   a_pin_falls: assert property (cycle_end_in && !trigger_a_or_b_out
      |=> !frame_sync_pin0_out)
      else $error("monitor pin still high after cycle end");
endmodule
bind atdu_trigger_unit atdu_checker u_chk (.clk_sys_in(clk_sys_in),
   .rst_n_in(rst_n_in), .ce_in(ce_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
   .timer_mode_in(timer_mode_in), .count_down_in(count_down_in),
   .cycle_end_in(cycle_end_in), .trigger_a_out(trigger_a_out),
   .trigger_b_out(trigger_b_out), .trigger_a_or_b_out(trigger_a_or_b_out),
   .frame_sync_pin0_out(frame_sync_pin0_out),
   .frame_sync_oe0_n_out(frame_sync_oe0_n_out));
`default_nettype wire

// >>> atdu_adc_model.sv
// converter model: counts conversion starts on both trigger lines
// assumes starts are sampled on clk_sys_in like the timer
`timescale 1ns/1ps
`default_nettype none
module atdu_adc_model (
   input wire logic  clk_sys_in,
   input wire logic  rst_n_in,
   input wire logic  start_a_in,
   input wire logic  start_b_in,
   output logic [7:0] conv_a_out,
   output logic [7:0] conv_b_out
);
   // one conversion per high cycle, so a stretched start counts once for every cycle it stays high
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         conv_a_out <= 8'h00;
         conv_b_out <= 8'h00;
      end else begin
         conv_a_out <= conv_a_out + {7'h00, start_a_in};
         conv_b_out <= conv_b_out + {7'h00, start_b_in};
      end
   end
endmodule
`default_nettype wire

// >>> adc_trigger_delay_unit_tb.sv
// testbench for the adc trigger delay unit with the converter model
// assumes a 10 mhz clock, bus master and timer strobes driven here
`timescale 1ns/1ps
`default_nettype none
module adc_trigger_delay_unit_tb;
   typedef struct {logic [1:0] m; logic [7:0] ctl; logic [15:0] ca, cb, c;
      logic d, ea, eb;} atdu_row_t;
   logic        clk_sys_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic [4:0]  addr = 5'h00;
   logic        rd = 1'b0, wr = 1'b0, down = 1'b0, ce = 1'b1, e, src_ok;
   logic [31:0] wdata = 32'h0, q;
   logic [15:0] cnt = 16'hffff, cur, v;
   logic [1:0]  mode = 2'h0;
   logic [4:0]  ev = 5'h00;
   logic [7:0]  na, nb, conv_a, conv_b;
   logic [7:0]  mons [0:4] = '{8'h89, 8'h8a, 8'h8c, 8'h09, 8'h81};
   wire  [31:0] rdata;
   wire         stall, trg_a, trg_b, trg_ab, pin0, oe0_n, pin1, oe1_n;
   int          err_total = 0, n_tests = 0, cycles = 0;
   // mode, control, buffers a/b, counter, down, expected a/b starts
   atdu_row_t rows [0:6] = '{
      '{2'h0, 8'h41, 16'h0040, 16'h0080, 16'h0040, 0, 1, 0},
      '{2'h0, 8'h45, 16'h0041, 16'h0081, 16'h0081, 0, 0, 1},
      '{2'h1, 8'h45, 16'h0042, 16'h0082, 16'h0042, 1, 0, 0},
      '{2'h2, 8'h4a, 16'h0043, 16'h0083, 16'h0043, 1, 0, 0},
      '{2'h3, 8'h42, 16'h0044, 16'h0084, 16'h0044, 1, 1, 0},
      '{2'h3, 8'h42, 16'h0045, 16'h0085, 16'h0045, 0, 0, 0},
      '{2'h3, 8'h49, 16'h0046, 16'h0086, 16'h0086, 1, 0, 1}};
   always #50 clk_sys_in = ~clk_sys_in;
   atdu_trigger_unit uut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .ce_in(ce), .avs_address_in(addr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wdata),
      .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
      .avs_waitrequest_out(stall), .channel_counter_in(cnt),
      .count_down_in(down), .timer_mode_in(mode), .crest_in(ev[0]),
      .trough_in(ev[1]), .general_reg_a_match_in(ev[2]),
      .duty_reg_d_rewrite_in(ev[3]), .offset_cycle_value_in(16'h0300),
      .cycle_end_in(ev[4]), .trigger_a_out(trg_a), .trigger_b_out(trg_b),
      .trigger_a_or_b_out(trg_ab), .frame_sync_pin0_out(pin0),
      .frame_sync_oe0_n_out(oe0_n), .frame_sync_pin1_out(pin1),
      .frame_sync_oe1_n_out(oe1_n));
   atdu_adc_model adc (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .start_a_in(trg_a), .start_b_in(trg_b), .conv_a_out(conv_a),
      .conv_b_out(conv_b));
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic check(input [31:0] got, input [31:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input [4:0] a, input [31:0] d);
      @(posedge clk_sys_in);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      do @(posedge clk_sys_in); while (stall !== 1'b0);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic wreg(input [4:0] a, input [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rchk(input [4:0] a, input [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(q, exp);
   endtask
   // one-cycle timer strobe: crest, trough, match a, duty, cycle end
   task automatic pulse(input int k);
      @(posedge clk_sys_in);
      ev <= 5'h01 << k;
      @(posedge clk_sys_in);
      ev <= 5'h00;
   endtask
   // counter value for one cycle; returns where the trigger stands
   task automatic fire(input [15:0] c, input logic d);
      @(posedge clk_sys_in);
      cnt <= c;
      down <= d;
      @(posedge clk_sys_in);
      cnt <= 16'hffff;
      @(negedge clk_sys_in);
   endtask
   task final_report;
      if (err_total == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // hang guard, well above the fewer than a thousand cycles the run needs
   always @(posedge clk_sys_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total = err_total + 1;
         final_report;
      end
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      @(negedge clk_sys_in);
      check(stall, 1);
      check({oe1_n, oe0_n}, 2'h3);
      rchk(5'h00, 0);
      rchk(5'h14, 0);
      wreg(5'h04, 32'h1234);
      rchk(5'h04, 0);
      foreach (rows[i]) begin
         @(posedge clk_sys_in);
         mode <= rows[i].m;
         wreg(5'h00, {24'h0, rows[i].ctl});
         wreg(5'h0c, {16'h0, rows[i].ca});
         wreg(5'h10, {16'h0, rows[i].cb});
         pulse(rows[i].m == 2'h3 ? 0 : 2);
         rchk(5'h04, {16'h0, rows[i].ca});
         rchk(5'h08, {16'h0, rows[i].cb});
         na = conv_a;
         nb = conv_b;
         fire(rows[i].c, rows[i].d);
         @(negedge clk_sys_in);
         check(8'(conv_a - na), rows[i].ea);
         check(8'(conv_b - nb), rows[i].eb);
      end
      // every timing code in every mode, against crest, trough, match a
      cur = 16'h0046;
      for (int m = 0; m < 4; m++)
         for (int t = 0; t < 4; t++) begin
            @(posedge clk_sys_in);
            mode <= m[1:0];
            wreg(5'h00, {24'h0, t[1:0], 6'h00});
            for (int k = 0; k < 3; k++) begin
               v = 16'h0100 + 16'(m * 16 + t * 4 + k);
               wreg(5'h0c, {16'h0, v});
               pulse(k);
               if (m == 3 ? (k < 2 && t[k]) : (k == 2 && t == 1))
                  cur = v;
               rchk(5'h04, {16'h0, cur});
            end
         end
      wreg(5'h00, 32'h40);
      wreg(5'h0c, 32'h0222);
      pulse(3);
      rchk(5'h04, 32'h0222);
      // zero buffers copied at a trough mute the next up count
      wreg(5'h00, 32'h85);
      wreg(5'h0c, 0);
      wreg(5'h10, 0);
      pulse(1);
      fire(16'h0000, 1'b0);
      check({trg_a, trg_b}, 2'h0);
      wreg(5'h00, 32'h05);
      pulse(1);
      fire(16'h0000, 1'b0);
      check({trg_a, trg_b}, 2'h3);
      // offset-valued buffers copied at a crest mute the next down count
      wreg(5'h00, 32'h4a);
      wreg(5'h0c, 32'h0300);
      wreg(5'h10, 32'h0300);
      pulse(0);
      fire(16'h0300, 1'b1);
      check({trg_a, trg_b}, 2'h0);
      wreg(5'h00, 32'h0a);
      pulse(0);
      fire(16'h0300, 1'b1);
      check({trg_a, trg_b}, 2'h3);
      // monitor pins: each source code enabled, code 09 also disabled, plus an unknown code
      @(posedge clk_sys_in);
      mode <= 2'h0;
      wreg(5'h00, 32'h45);
      wreg(5'h0c, 32'h0010);
      wreg(5'h10, 32'h0020);
      pulse(2);
      wreg(5'h18, 32'h8c);
      foreach (mons[i]) begin
         wreg(5'h14, {24'h0, mons[i]});
         for (int k = 0; k < 2; k++) begin
            fire(k ? 16'h0020 : 16'h0010, 1'b0);
            @(negedge clk_sys_in);
            e = mons[i][7] && (mons[i][4:0] == 5'h0c ||
               mons[i][4:0] == (k ? 5'h0a : 5'h09));
            check(pin0, e);
            src_ok = mons[i][4:0] inside {5'h09, 5'h0a, 5'h0c};
            check(oe0_n, !(mons[i][7] && src_ok));
            check({pin1, oe1_n}, 2'h2);
            pulse(4);
            @(negedge clk_sys_in);
            check(pin0, 0);
         end
      end
      // frozen clock enable must swallow a transfer strobe
      wreg(5'h0c, 32'h0055);
      @(posedge clk_sys_in);
      ce <= 1'b0;
      pulse(2);
      @(posedge clk_sys_in);
      ce <= 1'b1;
      rchk(5'h04, 32'h0010);
      final_report;
   end
endmodule
`default_nettype wire
